// ### design/wsb_pkg.sv
// constants, types and state layout for the shift/digit/bit datapath
// assumes the core decoder presents one operation per request cycle
// Function
// RQ1: word left shift moves the pair up 0 to 7 places, zero into bit 0
// RQ2: after the word shift the sign flag equals result bit 15
// RQ3: after the word shift the zero flag shows an all-zero result
// RQ4: a word shift with nonzero count always clears the aux carry flag
// RQ5: parity flag set when the result low byte holds an even count of ones
// RQ6: carry flag holds the last bit shifted out of bit 15
// RQ7: a zero count leaves the operand and all five flags unchanged
// RQ8: right digit rotation moves acc low nibble and memory digits right
// RQ9: left digit rotation cycles acc low nibble and both memory digits leftward
// RQ10: bit transfer copies one bit either way between carry and bit operand
// RQ11: bit AND replaces carry with carry AND the selected bit
// RQ12: inverted-source AND uses the complement of the selected bit
// RQ13: bit OR replaces carry with carry OR the selected bit
// RQ14: inverted-source OR uses the complement of the selected bit
// RQ15: bit XOR replaces carry with carry XOR the bit, never inverted
// RQ16: bit invert flips the selected bit, carry included, in place
// RQ17: bit set forces the bit to one; flag targets change only that flag
// RQ18: bit clear forces the bit to zero; flag targets change only that flag
// RQ19: a bit of the 24-bit address space is read or modified alone
// RQ20: every byte write keeps all other bits of that byte
package wsb_pkg;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int NIB_W  = 4;
  localparam int CNT_W  = 3;
  localparam int IDX_W  = 3;
  localparam int WORD_MSB = 15;

  // flag positions inside the status word low byte
  localparam int SIGN_BIT  = 7;
  localparam int ZERO_BIT  = 6;
  localparam int AUX_BIT   = 4;
  localparam int PV_BIT    = 2;
  localparam int CARRY_BIT = 0;

  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    NO_OP                = 4'h0,
    WORD_SHIFT_LEFT_OP   = 4'h1,
    DIGIT_ROTATE_RIGHT_OP = 4'h2,
    DIGIT_ROTATE_LEFT_OP = 4'h3,
    BIT_TRANSFER_OP      = 4'h4,
    BIT_AND_OP           = 4'h5,
    BIT_OR_OP            = 4'h6,
    BIT_XOR_OP           = 4'h7,
    BIT_INVERT_OP        = 4'h8,
    BIT_SET_OP           = 4'h9,
    BIT_CLEAR_OP         = 4'hA
  } wsb_op_t;

  // where the selected bit lives
  typedef enum logic [1:0] {
    LOC_CARRY       = 2'h0,
    LOC_BYTE        = 2'h1,
    LOC_STATUS_LOW  = 2'h2
  } wsb_loc_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [BYTE_W-1:0] byteVal;
    logic [BYTE_W-1:0] acc;
    logic [BYTE_W-1:0] status;
    logic              wrWord;
    logic              wrByte;
    logic              wrAcc;
    logic              wrStatus;
    logic              done;
  } wsb_state_t;

  localparam wsb_state_t RST_STATE = '{
    word: RST_WORD, byteVal: RST_BYTE, acc: RST_BYTE, status: RST_BYTE,
    wrWord: 1'b0, wrByte: 1'b0, wrAcc: 1'b0, wrStatus: 1'b0, done: 1'b0
  };

endpackage

// ### design/wsb_word_shift_digit_rotate_bit_logic.sv
// word left shift, digit rotation and single-bit logic datapath
// assumes the decoder fetches operand bytes and writes results back itself
`timescale 1ns/100ps

module wsb_word_shift_digit_rotate_bit_logic
  import wsb_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // request from the decoder
  input  wire logic              opValid,
  input  wire logic [3:0]        opCode,
  input  wire logic [CNT_W-1:0]  shiftCount,
  input  wire logic [1:0]        bitLoc,
  input  wire logic [IDX_W-1:0]  bitIndex,
  input  wire logic              invertSrc,
  input  wire logic              toCarry,
  // operands from the register file and memory
  input  wire logic [WORD_W-1:0] register_pair,
  input  wire logic [BYTE_W-1:0] operandByte,
  input  wire logic [BYTE_W-1:0] accIn,
  input  wire logic [BYTE_W-1:0] status_word_low,
  // results and write strobes
  output logic [WORD_W-1:0]      resultWord,
  output logic [BYTE_W-1:0]      resultByte,
  output logic [BYTE_W-1:0]      resultAcc,
  output logic [BYTE_W-1:0]      resultStatus,
  output logic                   wordWrite,
  output logic                   byteWrite,
  output logic                   accWrite,
  output logic                   statusWrite,
  output logic                   opDone
);

  wsb_state_t state_q;
  wsb_state_t state_d;

  // shift with the last bit out kept on top
  function automatic logic [WORD_W:0] wsb_shl(
    input logic [WORD_W-1:0] w,
    input logic [CNT_W-1:0]  n
  );
    logic [WORD_W:0] r;
    r = {1'b0, w};
    for (int i = 0; i < 7; i++) begin
      if (i < int'(n)) begin
        r = {r[WORD_W-1:0], 1'b0};
      end
    end
    return r;
  endfunction

  // replace one bit, leave the rest of the byte
  function automatic logic [BYTE_W-1:0] wsb_put(
    input logic [BYTE_W-1:0] b,
    input logic [IDX_W-1:0]  idx,
    input logic              v
  );
    logic [BYTE_W-1:0] r;
    r = b;
    r[idx] = v;
    return r;
  endfunction

  // even-ones test, also used by the checks
  function automatic logic wsb_even(input logic [BYTE_W-1:0] b);
    return ~^b;
  endfunction

  // one decode of the request; result registered a cycle later
  always_comb begin
    logic [WORD_W:0]   shl;
    logic              carry;
    logic              srcBit;
    logic              newBit;
    logic              wrTarget;
    logic [BYTE_W-1:0] st;
    shl      = wsb_shl(register_pair, shiftCount);
    carry    = status_word_low[CARRY_BIT];
    // the carry location reads the flag itself, not a byte bit
    srcBit   = (wsb_loc_t'(bitLoc) == LOC_CARRY) ? carry :
               (wsb_loc_t'(bitLoc) == LOC_STATUS_LOW) ?
               status_word_low[bitIndex] : operandByte[bitIndex]; // RQ19
    newBit   = 1'b0;
    wrTarget = 1'b0;
    st       = status_word_low;
    state_d          = state_q;
    state_d.wrWord   = 1'b0;
    state_d.wrByte   = 1'b0;
    state_d.wrAcc    = 1'b0;
    state_d.wrStatus = 1'b0;
    state_d.done     = opValid;
    if (opValid) begin
      state_d.word    = register_pair;
      state_d.byteVal = operandByte;
      state_d.acc     = accIn;
      state_d.status  = status_word_low;
      unique case (wsb_op_t'(opCode))
        NO_OP: begin
        end
        WORD_SHIFT_LEFT_OP: begin
          // zero count is a no-op: nothing written, flags untouched
          if (shiftCount != '0) begin // RQ7
            state_d.word = shl[WORD_W-1:0]; // RQ1
            st[SIGN_BIT]  = shl[WORD_MSB]; // RQ2
            st[ZERO_BIT]  = (shl[WORD_W-1:0] == '0); // RQ3
            st[AUX_BIT]   = 1'b0; // RQ4
            st[PV_BIT]    = wsb_even(shl[BYTE_W-1:0]); // RQ5
            st[CARRY_BIT] = shl[WORD_W]; // RQ6
            state_d.status   = st;
            state_d.wrWord   = 1'b1;
            state_d.wrStatus = 1'b1;
          end
        end
        DIGIT_ROTATE_RIGHT_OP: begin
          state_d.acc = {accIn[BYTE_W-1:NIB_W],
                         operandByte[NIB_W-1:0]}; // RQ8
          state_d.byteVal = {accIn[NIB_W-1:0],
                             operandByte[BYTE_W-1:NIB_W]}; // RQ8
          state_d.wrAcc  = 1'b1;
          state_d.wrByte = 1'b1; // RQ20
        end
        DIGIT_ROTATE_LEFT_OP: begin
          state_d.acc = {accIn[BYTE_W-1:NIB_W],
                         operandByte[BYTE_W-1:NIB_W]}; // RQ9
          state_d.byteVal = {operandByte[NIB_W-1:0],
                             accIn[NIB_W-1:0]}; // RQ9
          state_d.wrAcc  = 1'b1;
          state_d.wrByte = 1'b1; // RQ20
        end
        BIT_TRANSFER_OP: begin
          if (toCarry) begin
            st[CARRY_BIT] = srcBit; // RQ10
            state_d.status   = st;
            state_d.wrStatus = 1'b1;
          end else begin
            newBit   = carry; // RQ10
            wrTarget = 1'b1;
          end
        end
        BIT_AND_OP: begin
          st[CARRY_BIT] = carry & (srcBit ^ invertSrc); // RQ11 RQ12
          state_d.status   = st;
          state_d.wrStatus = 1'b1;
        end
        BIT_OR_OP: begin
          st[CARRY_BIT] = carry | (srcBit ^ invertSrc); // RQ13 RQ14
          state_d.status   = st;
          state_d.wrStatus = 1'b1;
        end
        BIT_XOR_OP: begin
          // the inversion prefix does not exist here, so it is ignored
          st[CARRY_BIT] = carry ^ srcBit; // RQ15
          state_d.status   = st;
          state_d.wrStatus = 1'b1;
        end
        BIT_INVERT_OP: begin
          newBit   = ~srcBit; // RQ16
          wrTarget = 1'b1;
        end
        BIT_SET_OP: begin
          newBit   = 1'b1; // RQ17
          wrTarget = 1'b1;
        end
        BIT_CLEAR_OP: begin
          newBit   = 1'b0; // RQ18
          wrTarget = 1'b1;
        end
        default: begin
          // undefined code: answer done, write nothing
        end
      endcase
      // single-bit write-back to carry, status byte or operand byte
      if (wrTarget) begin
        unique case (wsb_loc_t'(bitLoc))
          LOC_CARRY: begin
            state_d.status   = wsb_put(status_word_low, IDX_W'(CARRY_BIT),
                                       newBit); // RQ17 RQ18
            state_d.wrStatus = 1'b1;
          end
          LOC_STATUS_LOW: begin
            state_d.status   = wsb_put(status_word_low, bitIndex,
                                       newBit); // RQ17 RQ18
            state_d.wrStatus = 1'b1;
          end
          LOC_BYTE: begin
            state_d.byteVal = wsb_put(operandByte, bitIndex, newBit); // RQ20
            state_d.wrByte  = 1'b1;
          end
          default: begin
            // illegal location: nothing is written
          end
        endcase
      end
      // illegal location: any bit operation is done-only, so a bad
      // decode can never disturb the carry or a neighbouring byte
      if (!(bitLoc inside {LOC_CARRY, LOC_BYTE, LOC_STATUS_LOW}) &&
          opCode inside {[BIT_TRANSFER_OP:BIT_CLEAR_OP]}) begin
        state_d.status   = status_word_low;
        state_d.byteVal  = operandByte;
        state_d.wrStatus = 1'b0;
        state_d.wrByte   = 1'b0;
      end
    end
  end

  // the only clocked process of the block
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the registered state
  assign resultWord   = state_q.word;
  assign resultByte   = state_q.byteVal;
  assign resultAcc    = state_q.acc;
  assign resultStatus = state_q.status;
  assign wordWrite    = state_q.wrWord;
  assign byteWrite    = state_q.wrByte;
  assign accWrite     = state_q.wrAcc;
  assign statusWrite  = state_q.wrStatus;
  assign opDone       = state_q.done;

  // checks: reference shift and request decodes
  logic [WORD_W:0] shlRef;
  logic            isShl;
  logic            isBitByteWr;
  logic            selBit;
  assign shlRef = {1'b0, register_pair} << shiftCount;
  assign isShl  = opValid && (opCode == WORD_SHIFT_LEFT_OP);
  assign selBit = operandByte[bitIndex];
  assign isBitByteWr = opValid && (bitLoc == LOC_BYTE) &&
                       (opCode == BIT_SET_OP || opCode == BIT_CLEAR_OP ||
                        opCode == BIT_INVERT_OP);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_SHIFT_VALUE: assert property ( // RQ1
    isShl && shiftCount != '0 |=>
      wordWrite && resultWord == $past(shlRef[WORD_W-1:0]))
    else $error("word shift result wrong");
  AST_SHIFT_SIGN: assert property ( // RQ2
    wordWrite |-> resultStatus[SIGN_BIT] == resultWord[WORD_MSB])
    else $error("sign flag wrong after word shift");
  AST_SHIFT_ZERO: assert property ( // RQ3
    wordWrite |-> resultStatus[ZERO_BIT] == (resultWord == '0))
    else $error("zero flag wrong after word shift");
  AST_SHIFT_AUX: assert property ( // RQ4
    wordWrite |-> !resultStatus[AUX_BIT] && statusWrite)
    else $error("aux carry not cleared by word shift");
  AST_SHIFT_PARITY: assert property ( // RQ5
    wordWrite |-> resultStatus[PV_BIT] == wsb_even(resultWord[7:0]))
    else $error("parity flag wrong after word shift");
  AST_SHIFT_CARRY: assert property ( // RQ6
    isShl && shiftCount != '0 |=>
      resultStatus[CARRY_BIT] == $past(shlRef[WORD_W]))
    else $error("carry is not the last bit out");
  AST_SHIFT_ZERO_COUNT: assert property ( // RQ7
    isShl && shiftCount == '0 |=> opDone && !wordWrite && !statusWrite)
    else $error("zero count shift wrote something");
  AST_ROTATE_RIGHT: assert property ( // RQ8
    opValid && opCode == DIGIT_ROTATE_RIGHT_OP |=>
      resultAcc == {$past(accIn[7:4]), $past(operandByte[3:0])} &&
      resultByte == {$past(accIn[3:0]), $past(operandByte[7:4])})
    else $error("right digit rotation wrong");
  AST_ROTATE_LEFT: assert property ( // RQ9
    opValid && opCode == DIGIT_ROTATE_LEFT_OP |=>
      resultAcc == {$past(accIn[7:4]), $past(operandByte[7:4])} &&
      resultByte == {$past(operandByte[3:0]), $past(accIn[3:0])})
    else $error("left digit rotation wrong");
  AST_AND_CARRY: assert property ( // RQ11 RQ12
    opValid && opCode == BIT_AND_OP && bitLoc == LOC_BYTE |=>
      resultStatus[CARRY_BIT] == ($past(status_word_low[CARRY_BIT]) &
                                 ($past(selBit) ^ $past(invertSrc))))
    else $error("bit AND carry wrong");
  AST_XOR_CARRY: assert property ( // RQ15
    opValid && opCode == BIT_XOR_OP && bitLoc == LOC_BYTE |=>
      resultStatus[CARRY_BIT] == ($past(status_word_low[CARRY_BIT]) ^
                                  $past(selBit)))
    else $error("bit XOR carry wrong");
  AST_BYTE_KEEP: assert property ( // RQ20
    isBitByteWr |=> byteWrite &&
      ((resultByte ^ $past(operandByte)) & ~(8'h01 << $past(bitIndex)))
        == 8'h00)
    else $error("bit write disturbed other bits");

  COV_SHIFT_CARRY: cover property (
    isShl && shiftCount == 3'h7 ##1 resultStatus[CARRY_BIT]);
  COV_ROTATE_BACK: cover property (
    opValid && opCode == DIGIT_ROTATE_RIGHT_OP ##1
    opValid && opCode == DIGIT_ROTATE_LEFT_OP);
  COV_INV_OR: cover property (
    opValid && opCode == BIT_OR_OP && invertSrc ##1 statusWrite);

endmodule

// ### testbench/wsb_core_regfile.sv
// register file model standing in for the core around the datapath
// assumes one-cycle write strobes and a bench-side load port
`timescale 1ns/100ps

module wsb_core_regfile
  import wsb_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // bench load port
  input  wire logic              ldEn,
  input  wire logic [WORD_W-1:0] ldWord,
  input  wire logic [BYTE_W-1:0] ldByte,
  input  wire logic [BYTE_W-1:0] ldAcc,
  input  wire logic [BYTE_W-1:0] ldStatus,
  // write-back from the datapath
  input  wire logic              wordWrite,
  input  wire logic              byteWrite,
  input  wire logic              accWrite,
  input  wire logic              statusWrite,
  input  wire logic [WORD_W-1:0] resultWord,
  input  wire logic [BYTE_W-1:0] resultByte,
  input  wire logic [BYTE_W-1:0] resultAcc,
  input  wire logic [BYTE_W-1:0] resultStatus,
  // operands toward the datapath
  output logic      [WORD_W-1:0] regPair_q,
  output logic      [BYTE_W-1:0] regByte_q,
  output logic      [BYTE_W-1:0] regAcc_q,
  output logic      [BYTE_W-1:0] regStatus_q
);
  // whole-byte write-back, so a lost neighbour bit shows on the next op
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {regPair_q, regByte_q, regAcc_q, regStatus_q} <= '0;
    end else if (ldEn) begin
      {regPair_q, regByte_q, regAcc_q, regStatus_q} <=
        {ldWord, ldByte, ldAcc, ldStatus};
    end else begin
      if (wordWrite) regPair_q <= resultWord;
      if (byteWrite) regByte_q <= resultByte;
      if (accWrite) regAcc_q <= resultAcc;
      if (statusWrite) regStatus_q <= resultStatus;
    end
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench: directed and random ops through the datapath
// assumes the partner register file feeds operands and takes write-backs
`timescale 1ns/100ps

module testbench;
  import wsb_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] w;
    logic [BYTE_W-1:0] b;
    logic [BYTE_W-1:0] a;
    logic [BYTE_W-1:0] s;
    logic [3:0]        wr;
  } wsb_exp_t;

  // stimulus, operands and results
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              opValid = 1'b0;
  logic [3:0]        opCode = 4'h0;
  logic [CNT_W-1:0]  shiftCount = '0;
  logic [1:0]        bitLoc = 2'h0;
  logic [IDX_W-1:0]  bitIndex = '0;
  logic              invertSrc = 1'b0;
  logic              toCarry = 1'b0;
  logic              ldEn = 1'b0;
  logic [39:0]       ldVal = '0;
  logic [WORD_W-1:0] pairOp, resultWord;
  logic [BYTE_W-1:0] byteOp, accOp, statOp;
  logic [BYTE_W-1:0] resultByte, resultAcc, resultStatus;
  logic              wordWrite, byteWrite, accWrite, statusWrite, opDone;
  int                error_cnt = 0;
  int                compares = 0;
  logic [31:0]       rng = 32'd60;
  logic [WORD_W-1:0] mw = '0;
  logic [BYTE_W-1:0] mb = '0, ma = '0, ms = '0;
  logic [31:0]       r1, r2;
  wsb_exp_t          expQ[$];
  wsb_exp_t          monEx;

  always #20 ref_clk = ~ref_clk;

  wsb_word_shift_digit_rotate_bit_logic
    wsb_word_shift_digit_rotate_bit_logic_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .opValid(opValid),
    .opCode(opCode), .shiftCount(shiftCount), .bitLoc(bitLoc),
    .bitIndex(bitIndex), .invertSrc(invertSrc), .toCarry(toCarry),
    .register_pair(pairOp), .operandByte(byteOp), .accIn(accOp),
    .status_word_low(statOp), .resultWord(resultWord),
    .resultByte(resultByte), .resultAcc(resultAcc),
    .resultStatus(resultStatus), .wordWrite(wordWrite),
    .byteWrite(byteWrite), .accWrite(accWrite),
    .statusWrite(statusWrite), .opDone(opDone));

  wsb_core_regfile wsb_core_regfile_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ldEn(ldEn),
    .ldWord(ldVal[39:24]), .ldByte(ldVal[23:16]), .ldAcc(ldVal[15:8]),
    .ldStatus(ldVal[7:0]), .wordWrite(wordWrite), .byteWrite(byteWrite),
    .accWrite(accWrite), .statusWrite(statusWrite),
    .resultWord(resultWord), .resultByte(resultByte),
    .resultAcc(resultAcc), .resultStatus(resultStatus),
    .regPair_q(pairOp), .regByte_q(byteOp), .regAcc_q(accOp),
    .regStatus_q(statOp));

  // xorshift, fixed start
  task automatic next_rand(output logic [31:0] r);
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    r = rng;
  endtask

  // write one bit into the byte or the status low byte
  function automatic void put(inout wsb_exp_t e, input logic [1:0] loc,
                              input logic [2:0] ix, input logic v);
    if (loc == 2'h1) begin
      e.b[ix] = v;
      e.wr[2] = 1'b1;
    end else begin
      e.s[(loc == 2'h0) ? 3'd0 : ix] = v;
      e.wr[0] = 1'b1;
    end
  endfunction

  // expected results from the mirrored register contents
  function automatic wsb_exp_t predict(input logic [3:0] op,
    input logic [2:0] n, input logic [1:0] loc, input logic [2:0] ix,
    input logic inv, input logic tc);
    wsb_exp_t e;
    logic bitv;
    logic [16:0] sh;
    e = '{w: mw, b: mb, a: ma, s: ms, wr: 4'h0};
    bitv = (loc == 2'h0) ? ms[0] : (loc == 2'h1) ? mb[ix] : ms[ix];
    sh = {1'b0, mw} << n;
    case (op)
      4'h1: if (n != 3'h0) begin
        e.w = sh[15:0];
        e.s[SIGN_BIT] = sh[15];
        e.s[ZERO_BIT] = (sh[15:0] == 16'h0000);
        e.s[AUX_BIT] = 1'b0;
        e.s[PV_BIT] = ~^sh[7:0];
        e.s[CARRY_BIT] = sh[16];
        e.wr = 4'b1001;
      end
      4'h2: begin
        e.a = {ma[7:4], mb[3:0]};
        e.b = {ma[3:0], mb[7:4]};
        e.wr = 4'b0110;
      end
      4'h3: begin
        e.a = {ma[7:4], mb[7:4]};
        e.b = {mb[3:0], ma[3:0]};
        e.wr = 4'b0110;
      end
      4'h4: if (loc != 2'h3) begin
        if (tc) put(e, 2'h0, ix, bitv);
        else put(e, loc, ix, ms[0]);
      end
      4'h5: if (loc != 2'h3) put(e, 2'h0, ix, ms[0] & (bitv ^ inv));
      4'h6: if (loc != 2'h3) put(e, 2'h0, ix, ms[0] | (bitv ^ inv));
      4'h7: if (loc != 2'h3) put(e, 2'h0, ix, ms[0] ^ bitv);
      4'h8: if (loc != 2'h3) put(e, loc, ix, ~bitv);
      4'h9: if (loc != 2'h3) put(e, loc, ix, 1'b1);
      4'hA: if (loc != 2'h3) put(e, loc, ix, 1'b0);
      default: e.wr = 4'h0;
    endcase
    return e;
  endfunction

  // optional reload, then one request; the next call waits out write-back
  task automatic run_op(input logic [3:0] op, input logic [2:0] n,
    input logic [1:0] loc, input logic [2:0] ix, input logic inv,
    input logic tc, input logic rl, input logic [39:0] v);
    wsb_exp_t e;
    @(posedge ref_clk);
    if (rl) begin
      ldEn <= 1'b1;
      ldVal <= v;
      {mw, mb, ma, ms} = v;
      @(posedge ref_clk);
      ldEn <= 1'b0;
    end
    opValid <= 1'b1;
    opCode <= op;
    shiftCount <= n;
    bitLoc <= (op == 4'h4 && loc == 2'h0) ? 2'h1 : loc;
    bitIndex <= ix;
    invertSrc <= inv;
    toCarry <= tc;
    e = predict(op, n, (op == 4'h4 && loc == 2'h0) ? 2'h1 : loc, ix, inv, tc);
    expQ.push_back(e);
    {mw, mb, ma, ms} = {e.w, e.b, e.a, e.s};
    @(posedge ref_clk);
    opValid <= 1'b0;
  endtask

  task automatic fail(input string m);
    error_cnt++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic cmp_word(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x) fail($sformatf("word %h exp %h", g, x));
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) fail($sformatf("byte %h exp %h", g, x));
  endtask

  task automatic cmp_strobe(input logic [3:0] g, input logic [3:0] x);
    compares++;
    if (g !== x) fail($sformatf("strobes %b exp %b", g, x));
  endtask

  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // result monitor: oldest note against each completion
  always @(posedge ref_clk) begin
    if (!sys_rst && opDone === 1'b1) begin
      if (expQ.size() == 0) begin
        fail("completion without request");
      end else begin
        monEx = expQ.pop_front();
        cmp_word(resultWord, monEx.w);
        cmp_byte(resultByte, monEx.b);
        cmp_byte(resultAcc, monEx.a);
        cmp_byte(resultStatus,
                 monEx.s);
        cmp_strobe({wordWrite, byteWrite, accWrite, statusWrite},
                   monEx.wr);
      end
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // shift boundaries: one step, all-zero result, full count, zero count
    run_op(4'h1, 3'd1, 2'h0, 3'd0, 1'b0, 1'b0, 1'b1, 40'h8001_0000_00);
    run_op(4'h1, 3'd7, 2'h0, 3'd0, 1'b0, 1'b0, 1'b1,
           40'h0200_0000_14);
    run_op(4'h1, 3'd7, 2'h0, 3'd0, 1'b0, 1'b0, 1'b1,
           40'hFFFF_0000_00);
    run_op(4'h1, 3'd0, 2'h0, 3'd0, 1'b0, 1'b0, 1'b1, 40'h1234_0000_FF);
    // every code at every location, except bit transfer at carry, run as byte
    for (int o = 0; o < 64; o++) begin
      next_rand(r1);
      next_rand(r2);
      run_op(o[5:2], r1[2:0], o[1:0], r1[5:3], r1[6], r1[7], 1'b1,
             {r2, r1[31:24]});
    end
    // random chains, reloading now and then
    for (int k = 0; k < 400; k++) begin
      next_rand(r1);
      next_rand(r2);
      run_op(r1[3:0], r1[6:4], r1[8:7], r1[11:9], r1[12], r1[13],
             r1[14] & r1[15], {r2, r1[31:24]});
    end
    repeat (4) @(posedge ref_clk);
    if (expQ.size() != 0) fail("missing completions");
    tally_and_finish();
  end

  // watchdog well beyond about 1100 cycles of traffic
  initial begin
    #(40 * 20000);
    fail("watchdog expired");
    tally_and_finish();
  end
endmodule
